// ---- design/bso_pkg.sv ----
// Purpose: constants and types for the black sync output block
// Assumes: AXI4-Lite register access, one word per setting
// Notes on behaviour
// - NTSC burst: 525 lines, 59.94 fields
// - PAL burst: 625 lines, 50 fields
// - CW 10 MHz only on outputs 3-6
// - group rate family picks HD rate set
// - white reference on line 10/7, field 1
// - field reference only on burst formats
// - signed offset is lines plus sub-line
// - vertical delay in whole signed lines
// - coarse frame-clock steps, 0.1 ns fine
// - vertical and coarse limits per format
// - time code only on burst, per output
// - source off, local, utc or program
// - word holds time, date and zone
// - insert only with source and line
// - one or two programmable insertion lines
// - drop frame only on 60-field burst
// - signed offset added to source time
// - drop frame skips 00 and 01
package bso_pkg;
	localparam int NUM_OUT_DEF = 6;
	localparam int GROUP_SIZE = 3;
	localparam int CW_FIRST_OUT = 2;
	localparam logic [7:0] FRAME_CLK_TENTHS_DEF = 8'h25;
	localparam logic [11:0] ADDR_RATE = 12'h000;
	localparam logic [3:0] OUT_PAGE = 4'h1;
	localparam int OUT_IDX_LSB = 5;
	localparam int OUT_IDX_W = 3;
	localparam logic [4:0] OFS_CFG = 5'h00;
	localparam logic [4:0] OFS_LINES = 5'h04;
	localparam logic [4:0] OFS_VDLY = 5'h08;
	localparam logic [4:0] OFS_HDLY = 5'h0c;
	localparam logic [4:0] OFS_TCOFS = 5'h10;
	localparam logic [4:0] OFS_STAT = 5'h14;
	localparam logic [31:0] MASK_RATE = 32'h0000_0003;
	localparam logic [31:0] MASK_CFG = 32'h0007_711f;
	localparam logic [31:0] MASK_LINES = 32'h0000_ffff;
	localparam logic [31:0] MASK_VDLY = 32'h0000_0fff;
	localparam logic [31:0] MASK_HDLY = 32'h00ff_ffff;
	localparam logic [31:0] MASK_TCOFS = 32'h9f3f_3f1f;
	localparam logic [31:0] RST_LINES = 32'h0000_100e;
	localparam int CFG_FREF = 8;
	localparam int CFG_SRC_LSB = 12;
	localparam int CFG_L1EN = 16;
	localparam int CFG_L2EN = 17;
	localparam int CFG_DF = 18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [10:0] LINES_NTSC = 11'h20d;
	localparam logic [10:0] LINES_PAL = 11'h271;
	localparam logic [12:0] CHZ_NTSC = 13'h176a;
	localparam logic [12:0] CHZ_PAL = 13'h1388;
	localparam logic [4:0] FREF_LINE_NTSC = 5'h0a;
	localparam logic [4:0] FREF_LINE_PAL = 5'h07;
	localparam int FINE_BURST = 100;
	localparam int FINE_TRI = 70;
	localparam int SEC_MIN = 60;
	localparam int HOURS_DAY = 24;
	localparam int FPS_NTSC = 30;
	localparam int FPS_PAL = 25;
	localparam int DF_SKIP = 2;
	localparam int DF_KEEP_MIN = 10;
	typedef enum logic [4:0] {
		FMT_NTSC = 5'h00, FMT_NTSCJ = 5'h01, FMT_PAL = 5'h02, FMT_PPS = 5'h03,
		FMT_CW10 = 5'h04, I1080_5994 = 5'h05, P1080_5994 = 5'h06, P1080_4795 = 5'h07,
		P1080_2997 = 5'h08, P1080_2398 = 5'h09, P720_5994 = 5'h0a, SF1080_2398 = 5'h0b,
		I1080_60 = 5'h0c, I1080_50 = 5'h0d, P1080_60 = 5'h0e, P1080_50 = 5'h0f,
		P1080_48 = 5'h10, P1080_30 = 5'h11, P1080_25 = 5'h12, P1080_24 = 5'h13,
		P720_60 = 5'h14, P720_50 = 5'h15, SF1080_24 = 5'h16, FMT_NONE = 5'h1f
	} bso_fmt_t;
	typedef enum logic [2:0] {
		SRC_OFF = 3'h0, SRC_LOCAL_DST = 3'h1, SRC_LOCAL_STD = 3'h2,
		SRC_UTC = 3'h3, SRC_PROGRAM = 3'h4
	} bso_src_t;
	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [7:0] zone;
	} bso_tc_t;
	typedef struct packed {
		bso_fmt_t fmt;
		logic fmtLegal;
		logic [10:0] lines;
		logic [12:0] fieldCentiHz;
		logic fieldRefEn;
		logic [4:0] fieldRefLine;
		logic signed [11:0] vDelay;
		logic signed [24:0] hDelay;
		logic line1En;
		logic line2En;
		logic [7:0] line1;
		logic [7:0] line2;
		logic dropFrame;
		logic [63:0] tcWord;
	} bso_out_t;
endpackage : bso_pkg

// ---- design/bso_black_outputs.sv ----
// Purpose: per-output configuration of the six black sync outputs
// Assumes: time sources arrive on ref_clk, outputs feed the generators
// Notes: illegal format selections read back but drive FMT_NONE
`timescale 1ns/1ps
module bso_black_outputs
	import bso_pkg::*;
#(
	parameter int NUM_OUT = NUM_OUT_DEF,
	parameter logic [7:0] FRAME_CLK_TENTHS = FRAME_CLK_TENTHS_DEF
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// axi4-lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// time sources
	input wire bso_tc_t tcLocalDst,
	input wire bso_tc_t tcLocalStd,
	input wire bso_tc_t tcUtc,
	input wire bso_tc_t tcProgram,
	// per-output settings
	output bso_out_t outCfg [NUM_OUT]
);
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s, input logic [31:0] m);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8+:8] = n[b*8+:8];
		return r & m;
	endfunction : wmerge

	function automatic logic outHit(input logic [11:0] a);
		return a[11:8] == OUT_PAGE && 32'(a[OUT_IDX_LSB+:OUT_IDX_W]) < NUM_OUT;
	endfunction : outHit

	function automatic logic isBurst(input bso_fmt_t f);
		return f == FMT_NTSC || f == FMT_NTSCJ || f == FMT_PAL;
	endfunction : isBurst

	function automatic logic fmtOk(input bso_fmt_t f, input int o, input logic fam);
		if (f <= FMT_PPS)
			return 1'b1;
		if (f == FMT_CW10)
			return o >= CW_FIRST_OUT;
		if (f <= SF1080_2398)
			return !fam;
		if (f <= SF1080_24)
			return fam;
		return 1'b0;
	endfunction : fmtOk

	function automatic logic [10:0] vLimit(input bso_fmt_t f);
		case (f)
			FMT_NTSC, FMT_NTSCJ: return LINES_NTSC;
			FMT_PAL: return 11'h4e2;
			P720_5994, P720_60, P720_50: return 11'h177;
			FMT_PPS, FMT_CW10, FMT_NONE: return 11'h000;
			default: return 11'h232;
		endcase
	endfunction : vLimit

	function automatic logic [19:0] hLimit(input bso_fmt_t f);
		case (f)
			FMT_NTSC, FMT_NTSCJ: return 20'd635556;
			FMT_PAL: return 20'd640000;
			I1080_60, P1080_30: return 20'd296296;
			I1080_5994, P1080_2997: return 20'd296593;
			I1080_50, P1080_25: return 20'd355556;
			P1080_60: return 20'd148148;
			P1080_5994: return 20'd148296;
			P1080_50: return 20'd177778;
			P1080_48: return 20'd185185;
			P1080_4795: return 20'd185370;
			P1080_24, SF1080_24: return 20'd370370;
			P1080_2398, SF1080_2398: return 20'd370741;
			P720_60: return 20'd222222;
			P720_5994: return 20'd222444;
			P720_50: return 20'd266667;
			default: return 20'd0;
		endcase
	endfunction : hLimit

	function automatic logic signed [24:0] clampS(input logic signed [24:0] v,
		input logic [19:0] lim);
		logic signed [24:0] l;
		l = $signed({5'h00, lim});
		return (v > l) ? l : ((v < -l) ? -l : v);
	endfunction : clampS

	function automatic logic [22:0] toFrames(input logic [4:0] h, input logic [5:0] m,
		input logic [5:0] s, input logic [4:0] f, input logic pal);
		logic [22:0] secs;
		secs = 23'((32'(h) * SEC_MIN + 32'(m)) * SEC_MIN + 32'(s));
		return pal ? 23'(secs * FPS_PAL + f) : 23'(secs * FPS_NTSC + f);
	endfunction : toFrames

	function automatic logic [7:0] bcd(input logic [6:0] v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction : bcd

	logic [1:0] rate_q, rate_d;
	logic [31:0] cfg_q [NUM_OUT];
	logic [31:0] cfg_d [NUM_OUT];
	logic [31:0] lines_q [NUM_OUT];
	logic [31:0] lines_d [NUM_OUT];
	logic [31:0] vdly_q [NUM_OUT];
	logic [31:0] vdly_d [NUM_OUT];
	logic [31:0] hdly_q [NUM_OUT];
	logic [31:0] hdly_d [NUM_OUT];
	logic [31:0] tcofs_q [NUM_OUT];
	logic [31:0] tcofs_d [NUM_OUT];
	bso_out_t outQ [NUM_OUT];
	bso_out_t outD [NUM_OUT];
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [11:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic awFire, wFire, doWrite, wOk;
	logic [11:0] wA;
	logic [31:0] wD;
	logic [3:0] wS;
	logic [OUT_IDX_W-1:0] wIdx, rIdx;

	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign outCfg = outQ;
	assign awFire = s_axi_awvalid && s_axi_awready;
	assign wFire = s_axi_wvalid && s_axi_wready;
	assign doWrite = (awHeld_q || awFire) && (wHeld_q || wFire);
	assign wA = awHeld_q ? awAddr_q : s_axi_awaddr;
	assign wD = wHeld_q ? wData_q : s_axi_wdata;
	assign wS = wHeld_q ? wStrb_q : s_axi_wstrb;
	assign wIdx = wA[OUT_IDX_LSB+:OUT_IDX_W];
	assign rIdx = s_axi_araddr[OUT_IDX_LSB+:OUT_IDX_W];

	// bus handshake and register writes
	always_comb
	begin
		awHeld_d = awHeld_q;
		awAddr_d = awAddr_q;
		wHeld_d = wHeld_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rate_d = rate_q;
		cfg_d = cfg_q;
		lines_d = lines_q;
		vdly_d = vdly_q;
		hdly_d = hdly_q;
		tcofs_d = tcofs_q;
		wOk = 1'b0;
		if (awFire)
		begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (wFire)
		begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (doWrite)
		begin
			wOk = 1'b1;
			if (wA == ADDR_RATE)
				rate_d = 2'(wmerge(32'(rate_q), wD, wS, MASK_RATE));
			else if (outHit(wA))
				case (wA[4:0])
					OFS_CFG: cfg_d[wIdx] = wmerge(cfg_q[wIdx], wD, wS, MASK_CFG);
					OFS_LINES: lines_d[wIdx] = wmerge(lines_q[wIdx], wD, wS, MASK_LINES);
					OFS_VDLY: vdly_d[wIdx] = wmerge(vdly_q[wIdx], wD, wS, MASK_VDLY);
					OFS_HDLY: hdly_d[wIdx] = wmerge(hdly_q[wIdx], wD, wS, MASK_HDLY);
					OFS_TCOFS: tcofs_d[wIdx] = wmerge(tcofs_q[wIdx], wD, wS, MASK_TCOFS);
					OFS_STAT: wOk = 1'b1;
					default: wOk = 1'b0;
				endcase
			else
				wOk = 1'b0;
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wOk ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read path, status shows the settings in force
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr == ADDR_RATE)
				rdata_d = 32'(rate_q);
			else if (outHit(s_axi_araddr))
				case (s_axi_araddr[4:0])
					OFS_CFG: rdata_d = cfg_q[rIdx];
					OFS_LINES: rdata_d = lines_q[rIdx];
					OFS_VDLY: rdata_d = vdly_q[rIdx];
					OFS_HDLY: rdata_d = hdly_q[rIdx];
					OFS_TCOFS: rdata_d = tcofs_q[rIdx];
					OFS_STAT: rdata_d = {28'h0000000, outQ[rIdx].dropFrame,
						outQ[rIdx].line1En | outQ[rIdx].line2En,
						outQ[rIdx].fieldRefEn, outQ[rIdx].fmtLegal};
					default: rresp_d = RESP_SLVERR;
				endcase
			else
				rresp_d = RESP_SLVERR;
		end
	end

	// effective per-output settings and time code word
	always_comb
	begin
		bso_fmt_t f;
		bso_tc_t src;
		logic burst, pal, vitc, df;
		logic [22:0] day, t, ofs;
		logic [31:0] ofsW, secs;
		logic [4:0] fr;
		logic [5:0] sc, mn;
		logic [4:0] hr;
		logic signed [24:0] hc;
		f = FMT_NONE;
		src = '0;
		burst = 1'b0;
		pal = 1'b0;
		vitc = 1'b0;
		df = 1'b0;
		day = '0;
		t = '0;
		ofs = '0;
		ofsW = '0;
		secs = '0;
		fr = '0;
		sc = '0;
		mn = '0;
		hr = '0;
		hc = '0;
		for (int o = 0; o < NUM_OUT; o++)
		begin
			f = bso_fmt_t'(cfg_q[o][4:0]);
			outD[o].fmtLegal = fmtOk(f, o, (o < GROUP_SIZE) ? rate_q[0] : rate_q[1]);
			f = outD[o].fmtLegal ? f : FMT_NONE;
			outD[o].fmt = f;
			burst = isBurst(f);
			pal = f == FMT_PAL;
			outD[o].lines = !burst ? 11'h000 : (pal ? LINES_PAL : LINES_NTSC);
			outD[o].fieldCentiHz = !burst ? 13'h0000 : (pal ? CHZ_PAL : CHZ_NTSC);
			outD[o].fieldRefEn = burst && cfg_q[o][CFG_FREF];
			outD[o].fieldRefLine = pal ? FREF_LINE_PAL : FREF_LINE_NTSC;
			// signed totals: negative values advance the output
			outD[o].vDelay = 12'(clampS(25'($signed(vdly_q[o][11:0])), 20'(vLimit(f))));
			// widen both factors first so a full-scale coarse count cannot wrap
			hc = 25'($signed(hdly_q[o][15:0])) * 25'($signed({1'b0, FRAME_CLK_TENTHS}));
			outD[o].hDelay = clampS(hc, hLimit(f)) + clampS(25'($signed(hdly_q[o][23:16])),
				burst ? 20'(FINE_BURST) : 20'(FINE_TRI));
			case (bso_src_t'(cfg_q[o][CFG_SRC_LSB+:3]))
				SRC_LOCAL_DST: src = tcLocalDst;
				SRC_LOCAL_STD: src = tcLocalStd;
				SRC_UTC: src = tcUtc;
				SRC_PROGRAM: src = tcProgram;
				default: src = '0;
			endcase
			vitc = burst && cfg_q[o][CFG_SRC_LSB+:3] inside {[3'h1:3'h4]};
			outD[o].line1En = vitc && cfg_q[o][CFG_L1EN];
			outD[o].line2En = vitc && cfg_q[o][CFG_L2EN];
			outD[o].line1 = lines_q[o][7:0];
			outD[o].line2 = lines_q[o][15:8];
			df = burst && !pal && cfg_q[o][CFG_DF];
			outD[o].dropFrame = df;
			ofsW = tcofs_q[o];
			day = pal ? 23'(HOURS_DAY * SEC_MIN * SEC_MIN * FPS_PAL)
				: 23'(HOURS_DAY * SEC_MIN * SEC_MIN * FPS_NTSC);
			ofs = toFrames(ofsW[28:24], ofsW[21:16], ofsW[13:8], ofsW[4:0], pal) % day;
			t = toFrames(src.hours, src.minutes, src.seconds, src.frames, pal) % day;
			t = 23'((32'(t) + (ofsW[31] ? 32'(day - ofs) : 32'(ofs))) % 32'(day));
			fr = pal ? 5'(t % FPS_PAL) : 5'(t % FPS_NTSC);
			secs = pal ? 32'(t / FPS_PAL) : 32'(t / FPS_NTSC);
			sc = 6'(secs % SEC_MIN);
			mn = 6'((secs / SEC_MIN) % SEC_MIN);
			hr = 5'(secs / (SEC_MIN * SEC_MIN));
			if (df && sc == 6'h00 && 32'(fr) < DF_SKIP && 32'(mn) % DF_KEEP_MIN != 0)
				fr = 5'(DF_SKIP);
			outD[o].tcWord = {src.zone, bcd(7'(src.day)), bcd(7'(src.month)), bcd(src.year),
				bcd(7'(hr)), bcd(7'(mn)), bcd(7'(sc)), bcd(7'(fr))};
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awHeld_q <= 1'b0;
			awAddr_q <= 12'h000;
			wHeld_q <= 1'b0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
			rate_q <= 2'h0;
			for (int o = 0; o < NUM_OUT; o++)
			begin
				cfg_q[o] <= 32'h0000_0000;
				lines_q[o] <= RST_LINES;
				vdly_q[o] <= 32'h0000_0000;
				hdly_q[o] <= 32'h0000_0000;
				tcofs_q[o] <= 32'h0000_0000;
				outQ[o] <= '0;
			end
		end
		else
		begin
			awHeld_q <= awHeld_d;
			awAddr_q <= awAddr_d;
			wHeld_q <= wHeld_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			rate_q <= rate_d;
			cfg_q <= cfg_d;
			lines_q <= lines_d;
			vdly_q <= vdly_d;
			hdly_q <= hdly_d;
			tcofs_q <= tcofs_d;
			outQ <= outD;
		end
	end

	AST_B_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	for (genvar g = 0; g < NUM_OUT; g++)
	begin : gChk
		AST_CW_PLACE: assert property (@(posedge ref_clk) disable iff (!resetn)
			g < CW_FIRST_OUT |-> outQ[g].fmt != FMT_CW10)
			else $error("cw on low output");
		AST_FAMILY: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].fmt inside {[I1080_5994:SF1080_2398]} |->
			!$past(g < GROUP_SIZE ? rate_q[0] : rate_q[1]))
			else $error("hd rate family mismatch");
		AST_LINES: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].fmt == FMT_PAL |-> outQ[g].lines == LINES_PAL &&
			outQ[g].fieldRefLine == FREF_LINE_PAL)
			else $error("pal structure wrong");
		AST_FREF: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].fieldRefEn |-> isBurst(outQ[g].fmt) && $past(cfg_q[g][CFG_FREF]))
			else $error("field reference off burst");
		AST_VLIM: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].vDelay <= $signed({1'b0, vLimit(outQ[g].fmt)}) &&
			outQ[g].vDelay >= -$signed({1'b0, vLimit(outQ[g].fmt)}))
			else $error("vertical delay out of range");
		AST_INSERT: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].line1En |-> isBurst(outQ[g].fmt) && $past(cfg_q[g][CFG_SRC_LSB+:3]) != SRC_OFF)
			else $error("insertion without source");
		AST_DF_FMT: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].dropFrame |-> outQ[g].fmt inside {FMT_NTSC, FMT_NTSCJ})
			else $error("drop frame on wrong format");
		AST_DF_SKIP: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].dropFrame && outQ[g].tcWord[15:8] == 8'h00 && outQ[g].tcWord[19:16] != 4'h0
			|-> outQ[g].tcWord[7:0] >= 8'h02)
			else $error("drop frame count not skipped");
		AST_FR_RANGE: assert property (@(posedge ref_clk) disable iff (!resetn)
			outQ[g].tcWord[7:0] < (outQ[g].fmt == FMT_PAL ? 8'h25 : 8'h30) &&
			outQ[g].tcWord[31:24] < 8'h24)
			else $error("time code digit out of range");
	end
endmodule : bso_black_outputs

// ---- verif/bso_time_src.sv ----
// Purpose: time source feeder standing in for the time-of-day and program counters
// Assumes: loads land on the next rising edge of ref_clk
// Notes: index 0 local dst, 1 local std, 2 utc, 3 program
`timescale 1ns/1ps
module bso_time_src
	import bso_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// time sources
	output bso_tc_t  tcLocalDst = '0,
	output bso_tc_t  tcLocalStd = '0,
	output bso_tc_t  tcUtc = '0,
	output bso_tc_t  tcProgram = '0
);
	bso_tc_t pend [4] = '{default: '0};

	task automatic load(input int k, input bso_tc_t v);
		pend[k] = v;
	endtask : load

	// values move only on the rising clock edge, through nonblocking updates in that edge's own time step
	always @(posedge ref_clk)
	begin
		tcLocalDst <= pend[0];
		tcLocalStd <= pend[1];
		tcUtc <= pend[2];
		tcProgram <= pend[3];
	end
endmodule : bso_time_src

// ---- verif/test_bso_black_outputs.sv ----
// Purpose: self-checking bench for the black sync output block
// Assumes: default parameters, one bus transfer at a time
// Notes: settings are sampled on the falling edge after they have landed
`timescale 1ns/1ps
module test_bso_black_outputs
	import bso_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [11:0] awAddr = '0;
	logic [11:0] arAddr = '0;
	logic [31:0] wData = '0;
	logic [3:0]  wStrb = 4'hf;
	logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp;
	logic [31:0] rData;
	bso_tc_t     tcDst, tcStd, tcUtc, tcPrg;
	bso_out_t    outCfg [6];
	int          failures = 0;
	int          n_checks = 0;

	always #2.5 ref_clk = ~ref_clk;

	bso_time_src src_u (.ref_clk(ref_clk), .tcLocalDst(tcDst), .tcLocalStd(tcStd),
		.tcUtc(tcUtc), .tcProgram(tcPrg));

	bso_black_outputs dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .tcLocalDst(tcDst),
		.tcLocalStd(tcStd), .tcUtc(tcUtc), .tcProgram(tcPrg), .outCfg(outCfg));

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tmo();
		failures++;
		$display("ERROR bus answer expected 1 seen 0");
		test_done();
	endtask : tmo

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge ref_clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(negedge ref_clk);
			aw = awValid && awReady;
			w = wValid && wReady;
			b = bValid === 1'b1;
			r = bResp;
			@(posedge ref_clk);
			if (aw)
				awValid <= 1'b0;
			if (w)
				wValid <= 1'b0;
			if (b)
			begin
				bReady <= 1'b0;
				return;
			end
		end
		tmo();
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t, v;
		@(posedge ref_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(negedge ref_clk);
			t = arValid && arReady;
			v = rValid === 1'b1;
			d = rData;
			r = rResp;
			@(posedge ref_clk);
			if (t)
				arValid <= 1'b0;
			if (v)
			begin
				rReady <= 1'b0;
				@(negedge ref_clk);
				return;
			end
		end
		tmo();
	endtask : rd

	task automatic w_ok(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", RESP_OKAY, r);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : w_ok

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", RESP_OKAY, r);
	endtask : rchk

	function automatic logic [11:0] ra(input int n, input logic [4:0] o);
		return {OUT_PAGE, 3'(n), o};
	endfunction : ra

	function automatic logic [31:0] cw(logic [4:0] f, bit fr, int s, bit l1, bit l2, bit df);
		return {13'h0, df, l2, l1, 1'b0, 3'(s), 3'h0, fr, 3'h0, f};
	endfunction : cw

	function automatic logic [31:0] ofsw(bit n, int h, int m, int s, int f);
		return {n, 2'h0, 5'(h), 2'h0, 6'(m), 2'h0, 6'(s), 3'h0, 5'(f)};
	endfunction : ofsw

	function automatic bso_tc_t tcv(int h, int m, int s, int f);
		return '{hours: 5'(h), minutes: 6'(m), seconds: 6'(s), frames: 5'(f),
			year: 7'd25, month: 4'd7, day: 5'd19, zone: 8'h3c};
	endfunction : tcv

	function automatic logic [7:0] bcd(int v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction : bcd

	function automatic logic [63:0] tw(bso_tc_t t);
		return {t.zone, bcd(t.day), bcd(t.month), bcd(t.year), bcd(t.hours),
			bcd(t.minutes), bcd(t.seconds), bcd(t.frames)};
	endfunction : tw

	task automatic sc_reset();
		rchk("lines_reg", ra(0, OFS_LINES), RST_LINES);
		rchk("cfg_reg", ra(0, OFS_CFG), 32'h0);
		chk("fmtLegal", 1, outCfg[0].fmtLegal);
		chk("lines", 525, outCfg[0].lines);
		chk("fieldHz", 5994, outCfg[0].fieldCentiHz);
	endtask : sc_reset

	task automatic sc_fmt();
		logic [4:0] f [5] = '{FMT_NTSC, FMT_NTSCJ, FMT_PAL, FMT_PPS, FMT_CW10};
		logic       ok;
		for (int n = 0; n < 6; n++)
			for (int k = 0; k < 5; k++)
			begin
				ok = (k != 4) || (n >= CW_FIRST_OUT);
				w_ok(ra(n, OFS_CFG), cw(f[k], 1, 0, 0, 0, 0));
				chk("fmtLegal", ok, outCfg[n].fmtLegal);
				chk("fmt", ok ? f[k] : FMT_NONE, outCfg[n].fmt);
				chk("fieldRefEn", k < 3, outCfg[n].fieldRefEn);
			end
		rchk("cfg_reg", ra(0, OFS_CFG), cw(FMT_CW10, 1, 0, 0, 0, 0));
		w_ok(ra(0, OFS_CFG), cw(FMT_NTSC, 1, 0, 0, 0, 0));
		w_ok(ra(1, OFS_CFG), cw(FMT_PAL, 1, 0, 0, 0, 0));
		chk("lines", 625, outCfg[1].lines);
		chk("fieldHz", 5000, outCfg[1].fieldCentiHz);
		chk("refLine", 7, outCfg[1].fieldRefLine);
		chk("refLine", 10, outCfg[0].fieldRefLine);
		rchk("stat", ra(1, OFS_STAT), 32'h3);
	endtask : sc_fmt

	task automatic sc_rate();
		logic ok;
		for (int r = 1; r < 3; r++)
		begin
			w_ok(ADDR_RATE, 32'(r));
			for (int n = 0; n < 6; n += 3)
				for (int c = 5; c < 23; c++)
				begin
					ok = (c > 11) == r[n / 3];
					w_ok(ra(n, OFS_CFG), cw(5'(c), 1, 0, 0, 0, 0));
					chk("fmtLegal", ok, outCfg[n].fmtLegal);
					chk("fieldRefEn", 0, outCfg[n].fieldRefEn);
				end
		end
	endtask : sc_rate

	task automatic sc_delay();
		logic [4:0] f [6] = '{FMT_NTSC, FMT_NTSC, FMT_NTSC, FMT_PAL, P720_5994, I1080_5994};
		int         v [6] = '{-5, 600, -600, 2047, 400, -600};
		int         e [6] = '{-5, 525, -525, 1250, 375, -562};
		int         h;
		w_ok(ADDR_RATE, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			h = 2 * int'(FRAME_CLK_TENTHS_DEF) - (k < 4 ? FINE_BURST : FINE_TRI);
			w_ok(ra(2, OFS_CFG), cw(f[k], 0, 0, 0, 0, 0));
			w_ok(ra(2, OFS_VDLY), 32'(v[k]) & MASK_VDLY);
			w_ok(ra(2, OFS_HDLY), 32'h0088_0002);
			chk("vDelay", 64'(e[k]), 64'(outCfg[2].vDelay));
			chk("hDelay", 64'(h), 64'(outCfg[2].hDelay));
		end
		w_ok(ra(2, OFS_HDLY), 32'h0005_ffff);
		h = 5 - int'(FRAME_CLK_TENTHS_DEF);
		chk("hDelay", 64'(h), 64'(outCfg[2].hDelay));
		w_ok(ra(2, OFS_CFG), cw(FMT_NTSC, 0, 0, 0, 0, 0));
		w_ok(ra(2, OFS_HDLY), 32'h0000_7fff);
		chk("hDelay", 64'h0009_b2a4, 64'(outCfg[2].hDelay));
	endtask : sc_delay

	task automatic sc_tc();
		bso_tc_t t [4];
		for (int s = 0; s < 4; s++)
		begin
			t[s] = tcv(s + 1, 10 + s, 20 + s, 3 + s);
			src_u.load(s, t[s]);
		end
		for (int s = 1; s < 5; s++)
		begin
			w_ok(ra(3, OFS_CFG), cw(FMT_NTSC, 0, s, 1, 0, 0));
			chk("tcWord", tw(t[s - 1]), outCfg[3].tcWord);
		end
		chk("line1En", 1, outCfg[3].line1En);
		chk("line2En", 0, outCfg[3].line2En);
		chk("line1", 14, outCfg[3].line1);
		rchk("stat", ra(3, OFS_STAT), 32'h5);
		w_ok(ra(3, OFS_CFG), cw(FMT_NTSC, 0, 4, 0, 0, 0));
		chk("line1En", 0, outCfg[3].line1En);
		rchk("stat", ra(3, OFS_STAT), 32'h1);
		w_ok(ra(4, OFS_LINES), 32'h1513);
		w_ok(ra(4, OFS_TCOFS), ofsw(0, 2, 0, 0, 0));
		w_ok(ra(4, OFS_CFG), cw(FMT_PAL, 0, SRC_UTC, 1, 1, 0));
		chk("tcWord", tw(tcv(5, 12, 22, 5)), outCfg[4].tcWord);
		chk("tcWord", tw(t[3]), outCfg[3].tcWord);
		chk("line2En", 1, outCfg[4].line2En);
		chk("lines", 16'h1513, {outCfg[4].line2, outCfg[4].line1});
		w_ok(ra(3, OFS_CFG), cw(I1080_5994, 0, 4, 1, 1, 0));
		chk("lineEn", 0, {outCfg[3].line1En, outCfg[3].line2En});
	endtask : sc_tc

	task automatic sc_ofs();
		int c [6][15] = '{'{0, 0, 23, 59, 59, 29, 0, 0, 0, 0, 1, 0, 0, 0, 0},
			'{0, 0, 0, 30, 0, 0, 1, 1, 0, 0, 0, 23, 30, 0, 0},
			'{0, 1, 0, 0, 59, 29, 0, 0, 0, 0, 1, 0, 1, 0, 2},
			'{0, 1, 0, 9, 59, 29, 0, 0, 0, 0, 1, 0, 10, 0, 0},
			'{0, 0, 10, 20, 30, 15, 0, 1, 2, 3, 4, 11, 22, 33, 19},
			'{2, 1, 0, 0, 0, 24, 0, 0, 0, 0, 1, 0, 0, 1, 0}};
		for (int k = 0; k < 6; k++)
		begin
			src_u.load(2, tcv(c[k][2], c[k][3], c[k][4], c[k][5]));
			w_ok(ra(5, OFS_TCOFS), ofsw(c[k][6], c[k][7], c[k][8], c[k][9], c[k][10]));
			w_ok(ra(5, OFS_CFG), cw(5'(c[k][0]), 0, SRC_UTC, 1, 0, c[k][1]));
			chk("tcWord", tw(tcv(c[k][11], c[k][12], c[k][13], c[k][14])),
				outCfg[5].tcWord);
			chk("dropFrame", c[k][1] && c[k][0] < 2, outCfg[5].dropFrame);
		end
	endtask : sc_ofs

	task automatic sc_bus();
		logic [31:0] d;
		logic [1:0]  r;
		wr(ra(0, 5'h18), 32'h1, r);
		chk("bresp", RESP_SLVERR, r);
		rd(12'h800, d, r);
		chk("rresp", RESP_SLVERR, r);
		w_ok(ra(1, OFS_STAT), 32'hf);
		rchk("stat", ra(1, OFS_STAT), 32'h3);
		w_ok(ra(0, OFS_CFG), 32'hffff_ffff);
		rchk("cfg_reg", ra(0, OFS_CFG), MASK_CFG);
		w_ok(ADDR_RATE, 32'hffff_ffff);
		rchk("rate_reg", ADDR_RATE, MASK_RATE);
		// one byte lane only: the other lanes keep their old contents
		@(posedge ref_clk);
		wStrb <= 4'h2;
		w_ok(ra(0, OFS_CFG), 32'h0);
		rchk("cfg_reg", ra(0, OFS_CFG), MASK_CFG & 32'hffff_00ff);
		@(posedge ref_clk);
		wStrb <= 4'hf;
	endtask : sc_bus

	initial
	begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		sc_reset();
		sc_fmt();
		sc_rate();
		sc_delay();
		sc_tc();
		sc_ofs();
		sc_bus();
		test_done();
	end
endmodule : test_bso_black_outputs
